/* File: design/adr_ctrl_regs.v */
`timescale 1ns/100ps
`default_nettype none
`include "adr_consts.vh"

// Control and status register bank behind the two-wire control bus engine.
module adr_ctrl_regs #(
	parameter [7:0] REVISION = 8'h10, // Arbitrary revision value.
	parameter [7:0] IDENT    = 8'h5A  // Arbitrary identification code.
) (
	// Clock and reset.
	input  wire                  ref_clk,
	input  wire                  rst_n,
	// Byte port from the serial bus engine.
	input  wire                  addrLoad,
	input  wire [`ADR_AW-1:0]    addrIn,
	input  wire                  byteWrite,
	input  wire [`ADR_DW-1:0]    byteWrData,
	input  wire                  byteRead,
	output reg  [`ADR_DW-1:0]    byteRdData,
	output reg  [`ADR_AW-1:0]    addrCount,
	// Decoder core status.
	input  wire                  coreDecoding,
	input  wire                  errorEvent,
	input  wire [3:0]            errorCode,
	input  wire                  fracLoadDone,
	// Clock generator controls.
	output reg                   loadFraction,
	output reg                   refToOutputDivider,
	output reg                   refToCoreDivider,
	output reg                   vcoDisable,
	output reg                   systemClockToOutput,
	output reg                   outputClockPadEnable,
	output reg                   crystalDriveDisable,
	output reg                   bufferedMasterClockEnable,
	output reg  [`ADR_DW-1:0]    pllFeedbackFactor,
	output reg  [`ADR_DW-1:0]    pllInputFactor,
	// Bitstream input and playback controls.
	output reg                   sampleOnFallingEdge,
	output reg                   playActive,
	output reg                   muteActive,
	output reg                   outputClockRun,
	output reg                   softRestart,
	output reg                   interruptCmd
);
	reg  [7:0] polarity;
	reg  [3:0] lastError;
	reg        playReq;
	wire [7:0] scratchData;
	wire [`ADR_AW-1:0] rdPtr;
	wire       softWrite;
	reg  [7:0] next_rdData;

	// Writes to the soft restart location act at once; data is ignored.
	assign softWrite = byteWrite && (addrCount == `ADR_OFF_SOFTRST);
	// A read targets the address being loaded while addrLoad is high, otherwise the current counter value.
	assign rdPtr = addrLoad ? addrIn : addrCount;

	// Reserved locations get backing storage so stray accesses stay harmless.
	adr_reg_array uScratch (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.wrEn    (byteWrite),
		.wrAddr  (addrCount),
		.wrData  (byteWrData),
		.rdAddr  (rdPtr),
		.rdData  (scratchData)
	);

	// Address counter: loaded by the bus engine, then steps per data byte.
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			addrCount <= 7'h00;
		end else if (addrLoad) begin
			addrCount <= addrIn;
		end else if (byteWrite || byteRead) begin
			addrCount <= addrCount + 7'h01;
		end
	end

	// Clock control bits, one flop each so every control drives a pin directly.
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			loadFraction              <= 1'b1;
			refToOutputDivider        <= 1'b0;
			refToCoreDivider          <= 1'b0;
			vcoDisable                <= 1'b0;
			systemClockToOutput       <= 1'b0;
			outputClockPadEnable      <= 1'b1;
			crystalDriveDisable       <= 1'b0;
			bufferedMasterClockEnable <= 1'b0;
		end else if (byteWrite && addrCount == `ADR_OFF_CLKCTL) begin
			loadFraction              <= byteWrData[`ADR_CLK_LOADFRAC];
			refToOutputDivider        <= byteWrData[`ADR_CLK_REFOUT];
			refToCoreDivider          <= byteWrData[`ADR_CLK_REFCORE];
			vcoDisable                <= byteWrData[`ADR_CLK_VCODIS];
			systemClockToOutput       <= byteWrData[`ADR_CLK_SYSOUT];
			outputClockPadEnable      <= byteWrData[`ADR_CLK_PADEN];
			crystalDriveDisable       <= byteWrData[`ADR_CLK_XTALDIS];
			bufferedMasterClockEnable <= byteWrData[`ADR_CLK_BUFMCLK];
		end
	end

	// PLL factors and bitstream polarity. Firmware owns the factors; host
	// writes land but should not be made.
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			pllFeedbackFactor   <= `ADR_RST_PLLM;
			pllInputFactor      <= `ADR_RST_PLLN;
			polarity            <= `ADR_RST_POLARITY;
			sampleOnFallingEdge <= 1'b1;
		end else if (byteWrite) begin
			if (addrCount == `ADR_OFF_PLLM) begin
				pllFeedbackFactor <= byteWrData;
			end else if (addrCount == `ADR_OFF_PLLN) begin
				pllInputFactor <= byteWrData;
			end else if (addrCount == `ADR_OFF_POLARITY) begin
				polarity            <= byteWrData;
				sampleOnFallingEdge <= byteWrData[`ADR_POL_BIT];
			end
		end
	end

	// Last error: a new error wins over soft restart clearing in that cycle.
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			lastError <= `ADR_ERR_NONE;
		end else if (errorEvent) begin
			lastError <= errorCode;
		end else if (softWrite) begin
			lastError <= `ADR_ERR_NONE;
		end
	end

	// Command registers: only bit 0 is kept, so other bits read as zero.
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			playReq      <= 1'b0;
			muteActive   <= 1'b0;
			interruptCmd <= 1'b0;
			softRestart  <= 1'b0;
		end else begin
			softRestart <= softWrite;
			if (softWrite) begin
				playReq      <= 1'b0;
				interruptCmd <= 1'b0;
			end else if (byteWrite) begin
				if (addrCount == `ADR_OFF_PLAY) begin
					playReq <= byteWrData[0];
				end else if (addrCount == `ADR_OFF_MUTE) begin
					muteActive <= byteWrData[0];
				end else if (addrCount == `ADR_OFF_CMDINT) begin
					interruptCmd <= byteWrData[0];
				end
			end
		end
	end

	// Play only reaches the core while it decodes; mute never stops the clock.
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			playActive     <= 1'b0;
			outputClockRun <= 1'b1; // Follows the pad enable, which resets to 1.
		end else begin
			playActive     <= playReq & coreDecoding;
			outputClockRun <= outputClockPadEnable;
		end
	end

	// Read multiplexer; the soft restart location is write-only and reads zero.
	always @* begin
		next_rdData = scratchData;
		if (rdPtr == `ADR_OFF_REVISION) begin
			next_rdData = REVISION;
		end else if (rdPtr == `ADR_OFF_IDENT) begin
			next_rdData = IDENT;
		end else if (rdPtr == `ADR_OFF_CLKCTL) begin
			next_rdData = {bufferedMasterClockEnable, crystalDriveDisable,
				outputClockPadEnable, systemClockToOutput, vcoDisable,
				refToCoreDivider, refToOutputDivider, loadFraction};
		end else if (rdPtr == `ADR_OFF_PLLM) begin
			next_rdData = pllFeedbackFactor;
		end else if (rdPtr == `ADR_OFF_PLLN) begin
			next_rdData = pllInputFactor;
		end else if (rdPtr == `ADR_OFF_POLARITY) begin
			next_rdData = polarity;
		end else if (rdPtr == `ADR_OFF_ERROR) begin
			next_rdData = {4'h0, lastError};
		end else if (rdPtr == `ADR_OFF_SOFTRST) begin
			next_rdData = 8'h00;
		end else if (rdPtr == `ADR_OFF_PLAY) begin
			next_rdData = {7'h00, playReq};
		end else if (rdPtr == `ADR_OFF_MUTE) begin
			next_rdData = {7'h00, muteActive};
		end else if (rdPtr == `ADR_OFF_CMDINT) begin
			next_rdData = {7'h00, interruptCmd};
		end
	end

	// Read data is registered; the engine samples it a cycle after the address.
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			byteRdData <= 8'h00;
		end else begin
			byteRdData <= next_rdData;
		end
	end
endmodule // adr_ctrl_regs

`default_nettype wire

/* File: design/adr_consts.vh */
// Functional notes
// - Read-only 8-bit revision register at offset 0x00.
// - Read-only identifier at 0x01, fixed code, untouched by any reset.
// - Clock control bit 0 loads the PLL fraction; it is 1 after boot.
// - Clock control bit 1 feeds the output divider from the reference clock.
// - Clock control bit 2 feeds the core divider from the reference clock.
// - Clock control bit 3 disables the VCO output.
// - Clock control bit 4 puts the system clock on the output clock pin.
// - Clock control bit 5 enables the output clock pad; set on reset.
// - Clock control bit 6 disables the crystal drive pad.
// - Clock control bit 7 makes the shared pin a buffered master clock.
// - PLL factor registers 0x06 and 0x07 are read/write, owned by firmware.
// - Polarity 0x00: data launched falling, sampled on rising bit clock edge.
// - Polarity 0x04 (reset): data launched rising, sampled on falling edge.
// - Error register low nibble: 0 none, 1 CRC failure, 2 no data.
// - Any write to 0x10 soft resets: clears command, interrupt, goes idle.
// - Play bit 0 at 0x13 acts only while the decoder is decoding.
// - Mute bit 0 at 0x14 silences output but keeps the output clock running.
// - Internal address counter advances after each byte read or written.
`ifndef ADR_CONSTS_VH
`define ADR_CONSTS_VH

`define ADR_AW              7
`define ADR_DW              8
`define ADR_OFF_REVISION    7'h00
`define ADR_OFF_IDENT       7'h01
`define ADR_OFF_CLKCTL      7'h05
`define ADR_OFF_PLLM        7'h06
`define ADR_OFF_PLLN        7'h07
`define ADR_OFF_POLARITY    7'h0D
`define ADR_OFF_ERROR       7'h0F
`define ADR_OFF_SOFTRST     7'h10
`define ADR_OFF_PLAY        7'h13
`define ADR_OFF_MUTE        7'h14
`define ADR_OFF_CMDINT      7'h16
`define ADR_RST_CLKCTL      8'h21
`define ADR_RST_PLLM        8'h0C
`define ADR_RST_PLLN        8'h00
`define ADR_RST_POLARITY    8'h04
`define ADR_POL_BIT         2
`define ADR_ERR_NONE        4'h0
`define ADR_ERR_CRC         4'h1
`define ADR_ERR_NODATA      4'h2
`define ADR_CLK_LOADFRAC    0
`define ADR_CLK_REFOUT      1
`define ADR_CLK_REFCORE     2
`define ADR_CLK_VCODIS      3
`define ADR_CLK_SYSOUT      4
`define ADR_CLK_PADEN       5
`define ADR_CLK_XTALDIS     6
`define ADR_CLK_BUFMCLK     7

`endif

/* File: design/adr_reg_array.v */
`timescale 1ns/100ps
`default_nettype none
`include "adr_consts.vh"

// Generic 8-bit scratch storage for the reserved locations, with a registered read port.
module adr_reg_array (
	// Clock and reset.
	input  wire                  ref_clk,
	input  wire                  rst_n,
	// Write port.
	input  wire                  wrEn,
	input  wire [`ADR_AW-1:0]    wrAddr,
	input  wire [`ADR_DW-1:0]    wrData,
	// Read port.
	input  wire [`ADR_AW-1:0]    rdAddr,
	output reg  [`ADR_DW-1:0]    rdData
);
	reg [`ADR_DW-1:0] mem [0:15];

	// Small scratch store; only the low four address bits select a word.
	always @(posedge ref_clk) begin
		if (wrEn) begin
			mem[wrAddr[3:0]] <= wrData;
		end
		rdData <= mem[rdAddr[3:0]];
	end
endmodule // adr_reg_array

`default_nettype wire

/* File: verif/adr_ctrl_regs_properties.sv */
`timescale 1ns/100ps
`default_nettype none
// Watches the register bank ports; every check shares the one clock and its reset.
module adr_ctrl_regs_properties (
	// Clock, reset and host byte port.
	input wire logic       ref_clk, rst_n, addrLoad, byteWrite, byteRead,
	input wire logic [6:0] addrIn, addrCount,
	input wire logic [7:0] byteWrData, byteRdData,
	// Core status.
	input wire logic       coreDecoding, errorEvent, fracLoadDone,
	input wire logic [3:0] errorCode,
	// Control outputs.
	input wire logic       loadFraction, refToOutputDivider, refToCoreDivider, vcoDisable,
	input wire logic       systemClockToOutput, outputClockPadEnable, crystalDriveDisable,
	input wire logic       bufferedMasterClockEnable, sampleOnFallingEdge, playActive,
	input wire logic       muteActive, outputClockRun, softRestart, interruptCmd,
	input wire logic [7:0] pllFeedbackFactor, pllInputFactor
);
	// Clock control bits in register order, so whole bytes can be compared.
	wire [7:0] clkBits = {bufferedMasterClockEnable, crystalDriveDisable, outputClockPadEnable,
		systemClockToOutput, vcoDisable, refToCoreDivider, refToOutputDivider, loadFraction};
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_clk_write: assert property (byteWrite && addrCount == 7'h05
		|=> clkBits == $past(byteWrData)) else $error("Clock control differs from written byte.");
	a_clk_reset: assert property ($rose(rst_n)
		|-> clkBits == 8'h21 && outputClockRun) else $error("Clock control reset value wrong.");
	a_pll_reset: assert property ($rose(rst_n) |-> pllFeedbackFactor == 8'h0C
		&& pllInputFactor == 8'h00 && sampleOnFallingEdge) else $error("Factor reset wrong.");
	a_pol_write: assert property (byteWrite && addrCount == 7'h0D
		|=> sampleOnFallingEdge == $past(byteWrData[2])) else $error("Polarity not taken.");
	a_play_gate: assert property (playActive |-> $past(coreDecoding))
		else $error("Play active outside decoding.");
	a_mute_clock: assert property (muteActive |-> outputClockRun == outputClockPadEnable)
		else $error("Mute stopped the output clock.");
	a_addr_load: assert property (addrLoad |=> addrCount == $past(addrIn))
		else $error("Address counter not loaded.");
	a_addr_step: assert property ((byteWrite || byteRead) && !addrLoad
		|=> addrCount == $past(addrCount) + 7'h01) else $error("Address counter did not step.");
	a_soft_pulse: assert property (byteWrite && addrCount == 7'h10
		|=> softRestart ##1 !softRestart) else $error("Soft restart pulse wrong.");
	a_soft_clear: assert property (softRestart |-> ##2 !playActive && !interruptCmd)
		else $error("Soft restart left commands set.");
endmodule // adr_ctrl_regs_properties
bind adr_ctrl_regs adr_ctrl_regs_properties u_adr_ctrl_regs_properties (.*);
`default_nettype wire

/* File: verif/adr_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Host side of the byte port: each strobe is held over exactly one sampling edge.
module adr_host_model (
	// Clock and returned data.
	input wire logic       ref_clk,
	input wire logic [7:0] byteRdData,
	// Strobes and qualifiers.
	output var logic       addrLoad, byteWrite, byteRead,
	output var logic [6:0] addrIn,
	output var logic [7:0] byteWrData
);
	// Quiet bus at time zero.
	initial begin
		{addrLoad, byteWrite, byteRead} = 3'h0;
		addrIn = 7'h00;
		byteWrData = 8'h00;
	end
	// Only documented sub-addresses are ever loaded; released lines show the inverse.
	task setA(input logic [6:0] a);
		@(posedge ref_clk) #1;
		addrLoad = 1'b1;
		addrIn = a;
		@(posedge ref_clk) #1;
		addrLoad = 1'b0;
		addrIn = ~a;
	endtask
	// Whole bytes only, never to read-only locations; a blank edge keeps strobes apart.
	task wr(input logic [7:0] d);
		@(posedge ref_clk) #1;
		byteWrite = 1'b1;
		byteWrData = d;
		@(posedge ref_clk) #1;
		byteWrite = 1'b0;
		byteWrData = ~d;
	endtask
	// Read data is registered, so it is taken one edge after the counter settles.
	task rd(output logic [7:0] d);
		@(posedge ref_clk) #1;
		d = byteRdData;
		byteRead = 1'b1;
		@(posedge ref_clk) #1;
		byteRead = 1'b0;
	endtask
endmodule // adr_host_model
`default_nettype wire

/* File: verif/test_audio_decoder_ctrl_regs.sv */
`timescale 1ns/100ps
`default_nettype none
// Drives the bank through the host model and compares against the register map.
module test_audio_decoder_ctrl_regs;
	logic       ref_clk, rst_n, coreDecoding, errorEvent;
	wire        fracLoadDone;
	logic [3:0] errorCode;
	logic [7:0] v;
	wire        addrLoad, byteWrite, byteRead, loadFraction, refToOutputDivider, refToCoreDivider;
	wire        vcoDisable, systemClockToOutput, outputClockPadEnable, crystalDriveDisable;
	wire        bufferedMasterClockEnable, sampleOnFallingEdge, playActive, muteActive;
	wire        outputClockRun, softRestart, interruptCmd;
	wire [6:0]  addrIn, addrCount;
	wire [7:0]  byteWrData, byteRdData, pllFeedbackFactor, pllInputFactor;
	int         bad_count = 0;
	int         checks_done = 0;
	typedef struct {logic [6:0] a; logic [7:0] r, w, e;} adr_row_t;
	// Address, reset value, written byte, read-back; only the first four rows are written.
	adr_row_t rows [9] = '{'{7'h05, 8'h21, 8'hDE, 8'hDE}, '{7'h0D, 8'h04, 8'h00, 8'h00},
		'{7'h13, 8'h00, 8'hFF, 8'h01}, '{7'h14, 8'h00, 8'hFF, 8'h01}, '{7'h06, 8'h0C, 8'h00, 8'h00},
		'{7'h07, 8'h00, 8'h00, 8'h00}, '{7'h0F, 8'h00, 8'h00, 8'h00},
		'{7'h01, 8'h6B, 8'h00, 8'h00}, '{7'h00, 8'h3E, 8'h00, 8'h00}};
	// Identity values are arbitrary.
	adr_ctrl_regs #(.REVISION(8'h3E), .IDENT(8'h6B)) u_adr_ctrl_regs (.*);
	adr_host_model u_adr_host_model (.*);
	// The clock switch acknowledges whatever the fraction load bit asks for.
	assign fracLoadDone = loadFraction;
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checks_done++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task ra(input logic [6:0] a);
		u_adr_host_model.setA(a);
		u_adr_host_model.rd(v);
	endtask
	task end_of_test;
		if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Free-running 125 MHz clock.
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// The whole sequence needs well under a thousand cycles; this cuts a hang short.
	initial begin
		#100000;
		bad_count++;
		end_of_test;
	end
	// Main sequence.
	initial begin
		{rst_n, coreDecoding, errorEvent} = 3'h0;
		repeat (10) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		for (int i = 0; i < 9; i++) begin
			ra(rows[i].a);
			chk("reset value", v, rows[i].r);
			if (i < 4) begin
				u_adr_host_model.setA(rows[i].a);
				u_adr_host_model.wr(rows[i].w);
				ra(rows[i].a);
				chk("read back", v, rows[i].e);
			end
		end
		chk("clock bits", {bufferedMasterClockEnable, crystalDriveDisable, outputClockPadEnable,
			systemClockToOutput, vcoDisable, refToCoreDivider, refToOutputDivider,
			loadFraction}, 8'hDE);
		chk("sample edge", sampleOnFallingEdge, 1'b0);
		chk("play idle", playActive, 1'b0);
		coreDecoding = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1 chk("play decoding", playActive, 1'b1);
		chk("mute clock", {muteActive, outputClockRun}, 2'b10);
		for (int c = 1; c < 3; c++) begin
			@(posedge ref_clk) #1;
			errorEvent = 1'b1;
			errorCode = c[3:0];
			@(posedge ref_clk) #1;
			errorEvent = 1'b0;
			ra(7'h0F);
			chk("error code", v, {4'h0, c[3:0]});
		end
		u_adr_host_model.setA(7'h13);
		u_adr_host_model.wr(8'h01);
		u_adr_host_model.wr(8'h00);
		chk("counter", addrCount, 7'h15);
		ra(7'h14);
		chk("mute via counter", v, 8'h00);
		u_adr_host_model.setA(7'h16);
		u_adr_host_model.wr(8'hFF);
		chk("interrupt set", interruptCmd, 1'b1);
		ra(7'h16);
		chk("interrupt read", v, 8'h01);
		u_adr_host_model.setA(7'h13);
		u_adr_host_model.wr(8'h01);
		repeat (2) @(posedge ref_clk);
		#1 chk("play before soft", playActive, 1'b1);
		u_adr_host_model.setA(7'h10);
		u_adr_host_model.wr(8'h01);
		ra(7'h13);
		chk("play after soft", v, 8'h00);
		ra(7'h0F);
		chk("error after soft", v, 8'h00);
		chk("play out after soft", playActive, 1'b0);
		chk("interrupt after soft", interruptCmd, 1'b0);
		@(posedge ref_clk) #1 rst_n = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		ra(7'h05);
		chk("clock after reset", v, 8'h21);
		chk("feedback after reset", pllFeedbackFactor, 8'h0C);
		chk("input factor after reset", pllInputFactor, 8'h00);
		chk("clock run after reset", outputClockRun, 1'b1);
		ra(7'h01);
		chk("ident after reset", v, 8'h6B);
		end_of_test;
	end
endmodule // test_audio_decoder_ctrl_regs
`default_nettype wire
